// *** logic/vic_consts.svh ***
// Purpose: constants of the vectored interrupt controller
// Assumes: byte addresses relative to the block base
// Notes:   definitions only
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH

// register offsets
`define VIC_OFS_SETENA   12'h000
`define VIC_OFS_CLRENA   12'h080
`define VIC_OFS_SETPND   12'h100
`define VIC_OFS_CLRPND   12'h180
`define VIC_OFS_ACTIVE   12'h200
`define VIC_OFS_PRIO0    12'h300
`define VIC_OFS_PRIO7    12'h31C

// reset values
`define VIC_RST_WORD     32'h0000_0000

// vector table
`define VIC_TABLE_BASE   32'h0000_0000
`define VIC_SP_OFS       32'h0000_0000
`define VIC_IRQ_VEC_OFS  6'h10
`define VIC_IRQ_VEC_END  6'h30

// priority field inside each byte
`define VIC_PRIO_LSB     6
`define VIC_PRIO_NONE    3'h4

// fixed source lines
`define VIC_LINE_CAP0    23
`define VIC_LINE_CAP1    24
`define VIC_LINE_CMP     25
`define VIC_LINE_WAKE    28
`define VIC_RSVD_MASK    32'h0C12_0000
`define VIC_WAKE_MASK    32'h1004_303F

`endif

// *** logic/vic_ctrl.sv ***
// Purpose: nested vectored interrupt controller, 32 lines, APB registers
// Assumes: inputs synchronous to clk, core pulses ack and ret for one cycle
// Notes:   four priority levels held in bits [7:6] of each priority byte
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "vic_consts.svh"

module vic_ctrl
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                resetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic [31:0]              prdata,
    // interrupt sources
    input  wire logic [31:0]         periph_irq,
    input  wire logic                powerdown_wake_irq,
    input  wire logic                comparator_irq,
    input  wire logic                amplifier_irq,
    input  wire logic                input_capture0_irq,
    input  wire logic                input_capture1_irq,
    // core side
    input  wire vic_pkg::vic_core_s  core_in,
    output vic_pkg::vic_req_s        core_req,
    output logic [31:0]              sp_fetch_addr,
    output logic                     wake_req
);
    import vic_pkg::*;

    vic_apb_e    apb_r, apb_nxt;
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [31:0] en_r, en_nxt;
    logic [31:0] pend_r, pend_nxt;
    logic [31:0] act_r, act_nxt;
    logic [63:0] prio_r, prio_nxt;
    vic_req_s    req_r, req_nxt;
    logic [4:0]  offer_r, offer_nxt;
    logic [31:0] sp_r, sp_nxt;
    logic        wake_r, wake_nxt;

    logic [31:0] lines;
    logic [7:0]  best;
    logic [2:0]  run_prio;
    logic        wr_go;
    logic        hit;
    logic [31:0] rd_word;
    logic [2:0]  pidx;
    logic [31:0] taken;

    // lowest level wins, ties go to the lowest line number
    function automatic logic [7:0] pick_best(input logic [31:0] cand, input logic [63:0] pr);
        logic [7:0] b;
        b = 8'h00;
        for (int n = 0; n < 32; n++)
        begin
            if (cand[n] && (!b[7] || pr[2*n +: 2] < b[6:5]))
            begin
                b = {1'b1, pr[2*n +: 2], 5'(n)};
            end
        end
        return b;
    endfunction

    // level of the most urgent active handler, none reads as four
    function automatic logic [2:0] running(input logic [31:0] act, input logic [63:0] pr);
        logic [2:0] r;
        r = `VIC_PRIO_NONE;
        for (int n = 0; n < 32; n++)
        begin
            if (act[n] && {1'b0, pr[2*n +: 2]} < r)
            begin
                r = {1'b0, pr[2*n +: 2]};
            end
        end
        return r;
    endfunction

    // source line map
    always_comb
    begin
        lines = periph_irq & ~`VIC_RSVD_MASK;
        lines[`VIC_LINE_WAKE] = powerdown_wake_irq;
        lines[`VIC_LINE_CMP] = comparator_irq | amplifier_irq;
        lines[`VIC_LINE_CAP0] = input_capture0_irq;
        lines[`VIC_LINE_CAP1] = input_capture1_irq;
    end

    // apb read decode
    always_comb
    begin
        hit = 1'b1;
        rd_word = `VIC_RST_WORD;
        pidx = paddr[4:2];
        if (paddr[1:0] != 2'h0)
        begin
            hit = 1'b0;
        end
        else if (paddr == `VIC_OFS_SETENA || paddr == `VIC_OFS_CLRENA)
        begin
            rd_word = en_r;
        end
        else if (paddr == `VIC_OFS_SETPND || paddr == `VIC_OFS_CLRPND)
        begin
            rd_word = pend_r;
        end
        else if (paddr == `VIC_OFS_ACTIVE)
        begin
            rd_word = act_r;
        end
        else if (paddr >= `VIC_OFS_PRIO0 && paddr <= `VIC_OFS_PRIO7)
        begin
            for (int k = 0; k < 4; k++)
            begin
                rd_word[8*k+`VIC_PRIO_LSB +: 2] = prio_r[8*pidx + 2*k +: 2];
            end
        end
        else
        begin
            hit = 1'b0;
        end
    end

    assign wr_go = psel && penable && pready_r && pwrite && hit;

    // apb handshake, answers one cycle after setup
    always_comb
    begin
        apb_nxt = VIC_APB_IDLE;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        if (psel && !penable)
        begin
            apb_nxt = VIC_APB_ACC;
            pready_nxt = 1'b1;
            pslverr_nxt = !hit;
            prdata_nxt = pwrite ? `VIC_RST_WORD : rd_word;
        end
        else if (apb_r == VIC_APB_ACC && psel && !pready_r)
        begin
            apb_nxt = VIC_APB_ACC;
        end
    end

    // arbitration against the running handler
    // a line taken this cycle counts as active, so it is not offered twice
    always_comb
    begin
        taken = '0;
        if (core_in.ack && req_r.valid && en_r[offer_r])
        begin
            taken[offer_r] = 1'b1;
        end
        best = pick_best(pend_r & en_r & ~act_r & ~taken, prio_r);
        run_prio = running(act_r | taken, prio_r);
    end

    // enable, pending, active and priority state
    always_comb
    begin
        en_nxt = en_r;
        pend_nxt = pend_r;
        act_nxt = act_r;
        prio_nxt = prio_r;
        if (wr_go && paddr == `VIC_OFS_SETENA)
        begin
            en_nxt = en_r | pwdata;
        end
        if (wr_go && paddr == `VIC_OFS_CLRENA)
        begin
            en_nxt = en_r & ~pwdata;
        end
        if (wr_go && paddr == `VIC_OFS_CLRPND)
        begin
            pend_nxt = pend_nxt & ~pwdata;
        end
        if (wr_go && paddr >= `VIC_OFS_PRIO0 && paddr <= `VIC_OFS_PRIO7)
        begin
            for (int k = 0; k < 4; k++)
            begin
                prio_nxt[8*pidx + 2*k +: 2] = pwdata[8*k+`VIC_PRIO_LSB +: 2];
            end
        end
        if (core_in.ack && req_r.valid && en_r[offer_r])
        begin
            act_nxt[offer_r] = 1'b1;
            pend_nxt[offer_r] = 1'b0;
        end
        if (core_in.ret && core_in.ret_vec >= `VIC_IRQ_VEC_OFS && core_in.ret_vec < `VIC_IRQ_VEC_END)
        begin
            act_nxt[5'(core_in.ret_vec - `VIC_IRQ_VEC_OFS)] = 1'b0;
        end
        // hardware and software sets win over any clear
        pend_nxt = pend_nxt | lines;
        if (wr_go && paddr == `VIC_OFS_SETPND)
        begin
            pend_nxt = pend_nxt | pwdata;
        end
    end

    // request to the core
    always_comb
    begin
        req_nxt = '0;
        offer_nxt = offer_r;
        if (best[7] && {1'b0, best[6:5]} < run_prio)
        begin
            offer_nxt = best[4:0];
            req_nxt.valid = 1'b1;
            req_nxt.vec = {1'b0, best[4:0]} + `VIC_IRQ_VEC_OFS;
            req_nxt.addr = `VIC_TABLE_BASE + {24'h0, req_nxt.vec, 2'b00};
        end
        sp_nxt = `VIC_TABLE_BASE + `VIC_SP_OFS;
        wake_nxt = |(lines & `VIC_WAKE_MASK) | comparator_irq;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            apb_r <= VIC_APB_IDLE;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= `VIC_RST_WORD;
            en_r <= `VIC_RST_WORD;
            pend_r <= `VIC_RST_WORD;
            act_r <= `VIC_RST_WORD;
            prio_r <= '0;
            req_r <= '0;
            offer_r <= 5'h00;
            sp_r <= `VIC_TABLE_BASE + `VIC_SP_OFS;
            wake_r <= 1'b0;
        end
        else
        begin
            apb_r <= apb_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
            en_r <= en_nxt;
            pend_r <= pend_nxt;
            act_r <= act_nxt;
            prio_r <= prio_nxt;
            req_r <= req_nxt;
            offer_r <= offer_nxt;
            sp_r <= sp_nxt;
            wake_r <= wake_nxt;
        end
    end

    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;
    assign core_req = req_r;
    assign sp_fetch_addr = sp_r;
    assign wake_req = wake_r;

endmodule

// *** logic/vic_pkg.sv ***
// Purpose: types of the vectored interrupt controller
// Assumes: one clock domain
// Notes:   constants live in vic_consts.svh
package vic_pkg;

    typedef logic [1:0] vic_prio_t;

    typedef enum logic [0:0] {
        VIC_APB_IDLE = 1'b0,
        VIC_APB_ACC  = 1'b1
    } vic_apb_e;

    // request offered to the core
    typedef struct packed {
        logic        valid;
        logic [5:0]  vec;
        logic [31:0] addr;
    } vic_req_s;

    // answers from the core
    typedef struct packed {
        logic        ack;
        logic        ret;
        logic [5:0]  ret_vec;
    } vic_core_s;

endpackage

// *** tb/vic_assertions.sv ***
// Purpose: port assertions
// Assumes: one clock, sync reset
// Notes:   bound in the bench
`timescale 1ns/1ps
module vic_assertions
(
    // clock, reset, apb
    input wire logic               clk,
    input wire logic               resetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pready,
    input wire logic               pslverr,
    // sources, core
    input wire logic               comparator_irq,
    input wire logic               powerdown_wake_irq,
    input wire vic_pkg::vic_core_s core_in,
    input wire vic_pkg::vic_req_s  core_req,
    input wire logic [31:0]        sp_fetch_addr,
    input wire logic               wake_req
);
    import vic_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("long ready");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_sp; sp_fetch_addr == 32'h0; endproperty
    a_sp: assert property (p_sp) else $error("bad sp word");
    property p_adr; core_req.valid |-> core_req.addr == {24'h0, core_req.vec, 2'h0}; endproperty
    a_adr: assert property (p_adr) else $error("bad address");
    property p_vec; core_req.valid |-> core_req.vec inside {[6'h10:6'h2F]}; endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_wk; comparator_irq || powerdown_wake_irq |=> wake_req; endproperty
    a_wk: assert property (p_wk) else $error("no wake");
    property p_ack; core_in.ack && core_req.valid |=> !core_req.valid || core_req.vec != $past(core_req.vec); endproperty
    a_ack: assert property (p_ack) else $error("offer repeated");
    cover property (core_in.ack && core_req.valid);
    cover property (pslverr);
    cover property (wake_req);
endmodule

// *** tb/vic_core_model.sv ***
// Purpose: core side model
// Assumes: ack after dly cycles while auto
// Notes:   returns pulsed by the bench
`timescale 1ns/1ps
module vic_core_model
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // bench control
    input  wire logic              auto,
    input  wire logic [1:0]        dly,
    // controller side
    input  wire vic_pkg::vic_req_s req,
    output vic_pkg::vic_core_s     cin
);
    import vic_pkg::*;
    logic [1:0] cnt_r;
    initial cin = '0;
    always @(posedge clk)
    begin
        cin.ack <= 1'b0;
        if (!resetn || !req.valid || cin.ack)
            cnt_r <= 2'h0;
        else if (auto && cnt_r == dly)
            cin.ack <= 1'b1;
        else
            cnt_r <= cnt_r + 2'h1;
    end
    // one return pulse, vector scrambled after
    task ret(input logic [5:0] v);
        @(posedge clk);
        {cin.ret, cin.ret_vec} <= {1'b1, v};
        @(posedge clk);
        {cin.ret, cin.ret_vec} <= {1'b0, ~v};
    endtask
endmodule

// *** tb/vic_ctrl_tb.sv ***
// Purpose: self-checking bench
// Assumes: zero wait apb slave
// Notes:   random data, seed 61
`timescale 1ns/1ps
module vic_ctrl_tb;
    import vic_pkg::*;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, wake_req, err, auto;
    logic        powerdown_wake_irq, comparator_irq, amplifier_irq, input_capture0_irq, input_capture1_irq;
    logic [1:0]  dly;
    logic [4:0]  src;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, periph_irq, sp_fetch_addr, rd, m;
    vic_core_s   core_in;
    vic_req_s    core_req;
    int          fail_count, tests_run, seed, i;
    assign {powerdown_wake_irq, comparator_irq, amplifier_irq, input_capture1_irq, input_capture0_irq} = src;
    vic_ctrl dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
        .periph_irq, .powerdown_wake_irq, .comparator_irq, .amplifier_irq, .input_capture0_irq,
        .input_capture1_irq, .core_in, .core_req, .sp_fetch_addr, .wake_req);
    vic_core_model core (.clk, .resetn, .auto, .dly, .req(core_req), .cin(core_in));
    always #20 clk = ~clk;
    task give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task tmo;
        fail_count++;
        give_verdict();
    endtask
    task chk(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %0t exp %h got %h", $time, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 9 && pready !== 1'b1; n++)
            @(posedge clk);
        if (n == 9) tmo();
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b0;
    endtask
    task rc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(e, rd);
    endtask
    task wt(input logic v);
        int n;
        for (n = 0; n < 20 && core_req.valid !== v; n++)
            @(posedge clk);
        if (n == 20) tmo();
    endtask
    function automatic logic [31:0] src_bit(input int k);
        return k < 2 ? 32'h1 << (23 + k) : (k < 4 ? 32'h0200_0000 : 32'h1000_0000);
    endfunction
    initial
    begin
        {clk, resetn, psel, penable, pwrite, auto, dly, src, paddr, pwdata, periph_irq} = '0;
        {fail_count, tests_run, seed} = {32'h0, 32'h0, 32'd61};
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        for (i = 0; i < 8; i++)
            rc(12'(12'h300 + 4 * i), 32'h0);
        rc(12'h100, 32'h0);
        chk(32'h0, sp_fetch_addr);
        apb(1'b0, 12'h004, 32'h0);
        chk(32'h1, 32'(err));
        $display("test 1 done");
        m = $random(seed);
        apb(1'b1, 12'h000, m);
        apb(1'b1, 12'h000, 32'h0);
        rc(12'h080, m);
        apb(1'b1, 12'h080, m & 32'h0000FFFF);
        rc(12'h000, m & 32'hFFFF0000);
        apb(1'b1, 12'h080, 32'hFFFFFFFF);
        m = $random(seed);
        apb(1'b1, 12'h100, m);
        rc(12'h180, m);
        apb(1'b1, 12'h180, m);
        rc(12'h100, 32'h0);
        for (i = 0; i < 8; i++)
        begin
            m = $random(seed);
            apb(1'b1, 12'(12'h300 + 4 * i), m);
            rc(12'(12'h300 + 4 * i), m & 32'hC0C0C0C0);
        end
        $display("test 2 done");
        periph_irq <= 32'h0C120020;
        repeat (3) @(posedge clk);
        periph_irq <= 32'h0;
        rc(12'h100, 32'h20);
        chk(32'h0, 32'(core_req.valid));
        apb(1'b1, 12'h000, 32'h20);
        wt(1'b1);
        chk(32'd21, 32'(core_req.vec));
        chk(32'h54, core_req.addr);
        dly <= 2'($random(seed));
        auto <= 1'b1;
        wt(1'b0);
        apb(1'b1, 12'h080, 32'h20);
        apb(1'b1, 12'h180, 32'h20);
        rc(12'h200, 32'h20);
        core.ret(6'd21);
        rc(12'h200, 32'h0);
        $display("test 3 done");
        apb(1'b1, 12'h304, 32'h80000000);
        apb(1'b1, 12'h000, 32'hC0);
        apb(1'b1, 12'h100, 32'h80);
        wt(1'b1);
        wt(1'b0);
        auto <= 1'b0;
        apb(1'b1, 12'h304, 32'h80800000);
        apb(1'b1, 12'h100, 32'h40);
        repeat (3) @(posedge clk);
        chk(32'h0, 32'(core_req.valid));
        apb(1'b1, 12'h304, 32'h80400000);
        wt(1'b1);
        chk(32'd22, 32'(core_req.vec));
        apb(1'b1, 12'h080, 32'hFFFFFFFF);
        apb(1'b1, 12'h180, 32'hFFFFFFFF);
        core.ret(6'd23);
        rc(12'h200, 32'h0);
        $display("test 4 done");
        for (i = 0; i < 5; i++)
        begin
            src <= 5'(1 << i);
            repeat (3) @(posedge clk);
            chk(32'(i > 2), 32'(wake_req));
            src <= 5'h0;
            rc(12'h100, src_bit(i));
            apb(1'b1, 12'h180, 32'hFFFFFFFF);
        end
        apb(1'b1, 12'h000, 32'h10000000);
        src <= 5'h10;
        wt(1'b1);
        chk(32'd44, 32'(core_req.vec));
        chk(32'hB0, core_req.addr);
        auto <= 1'b1;
        wt(1'b0);
        rc(12'h200, 32'h10000000);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rc(12'h200, 32'h0);
        rc(12'h000, 32'h0);
        chk(32'h0, 32'(core_req.valid));
        $display("test 5 done");
        give_verdict();
    end
endmodule
bind vic_ctrl vic_assertions chk_i (.clk, .resetn, .psel, .penable, .pready, .pslverr, .comparator_irq,
    .powerdown_wake_irq, .core_in, .core_req, .sp_fetch_addr, .wake_req);
